// ===== bbsd_regs.sv
`timescale 1ns/1ns
module bbsd_regs
  import bbsd_pkg::*;
(
  input  wire logic          i_mclk,
  input  wire logic          i_reset_n,
  input  wire logic          i_cs_n,
  input  wire logic          i_sclk,
  input  wire logic          i_sdi,
  output logic               o_sdo,
  output logic               o_sdo_oe_n,
  output logic               o_shared_bias_enable,
  output logic [1:0]         o_stage1_gain_q,
  output logic [1:0]         o_stage1_gain_i,
  output logic [1:0]         o_stage2_gain_q,
  output logic [1:0]         o_stage2_gain_i,
  output logic [1:0]         o_stage3_gain_q,
  output logic [1:0]         o_stage3_gain_i,
  output logic [1:0]         o_filter_corner_q,
  output logic [1:0]         o_filter_corner_i,
  output logic [3:0]         o_attenuation_q,
  output logic [3:0]         o_attenuation_i,
  output logic [15:0]        o_integer_word,
  output logic [23:0]        o_primary_fraction_word,
  output logic [13:0]        o_aux_modulus,
  output logic               o_prescaler_enable,
  output logic               o_feedback_divider_enable,
  output logic [4:0]         o_reference_divide,
  output logic               o_cal_start
);
  import bbsd_pkg::*;

  bbsd_cfg_if cfg ();

  logic [7:0] bb_enable;
  logic [7:0] gain1;
  logic [7:0] gain2;
  logic [7:0] gain3;
  logic [7:0] filter_sel;
  logic [7:0] atten;
  logic [7:0] int_lo;
  logic [7:0] int_hi;
  logic [7:0] frac_lo;
  logic [7:0] frac_mid;
  logic [7:0] frac_hi;
  logic [7:0] mod_lo;
  logic [7:0] mod_hi;
  logic [7:0] div_mode;
  logic [7:0] ref_div;

  ////////////////////////////////////////////////////////////////////////
  // serial port front end
  bbsd_spi_engine u_engine (
    .i_mclk     (i_mclk),
    .i_reset_n  (i_reset_n),
    .i_cs_n     (i_cs_n),
    .i_sclk     (i_sclk),
    .i_sdi      (i_sdi),
    .o_sdo      (o_sdo),
    .o_sdo_oe_n (o_sdo_oe_n),
    .cfg        (cfg.engine)
  );

  ////////////////////////////////////////////////////////////////////////
  // address decode
  wire hit_bb_enable = cfg.addr == OFF_BB_ENABLE;
  wire hit_gain1 = cfg.addr == OFF_GAIN1;
  wire hit_gain2 = cfg.addr == OFF_GAIN2;
  wire hit_gain3 = cfg.addr == OFF_GAIN3;
  wire hit_filter = cfg.addr == OFF_FILTER;
  wire hit_atten = cfg.addr == OFF_ATTEN;
  wire hit_int_lo = cfg.addr == OFF_INT_LO;
  wire hit_int_hi = cfg.addr == OFF_INT_HI;
  wire hit_frac_lo = cfg.addr == OFF_FRAC_LO;
  wire hit_frac_mid = cfg.addr == OFF_FRAC_MID;
  wire hit_frac_hi = cfg.addr == OFF_FRAC_HI;
  wire hit_mod_lo = cfg.addr == OFF_MOD_LO;
  wire hit_mod_hi = cfg.addr == OFF_MOD_HI;
  wire hit_div_mode = cfg.addr == OFF_DIV_MODE;
  wire hit_ref_div = cfg.addr == OFF_REF_DIV;

  // write strobes; a write to an unmapped address is dropped
  wire wr_bb_enable = cfg.wr_stb & hit_bb_enable;
  wire wr_gain1 = cfg.wr_stb & hit_gain1;
  wire wr_gain2 = cfg.wr_stb & hit_gain2;
  wire wr_gain3 = cfg.wr_stb & hit_gain3;
  wire wr_filter = cfg.wr_stb & hit_filter;
  wire wr_atten = cfg.wr_stb & hit_atten;
  wire wr_int_lo = cfg.wr_stb & hit_int_lo;
  wire wr_int_hi = cfg.wr_stb & hit_int_hi;
  wire wr_frac_lo = cfg.wr_stb & hit_frac_lo;
  wire wr_frac_mid = cfg.wr_stb & hit_frac_mid;
  wire wr_frac_hi = cfg.wr_stb & hit_frac_hi;
  wire wr_mod_lo = cfg.wr_stb & hit_mod_lo;
  wire wr_mod_hi = cfg.wr_stb & hit_mod_hi;
  wire wr_div_mode = cfg.wr_stb & hit_div_mode;
  wire wr_ref_div = cfg.wr_stb & hit_ref_div;

  ////////////////////////////////////////////////////////////////////////
  // read-back selection; unmapped addresses read zero
  assign cfg.rdata = hit_bb_enable ? bb_enable :
                     hit_gain1     ? gain1 :
                     hit_gain2     ? gain2 :
                     hit_gain3     ? gain3 :
                     hit_filter    ? filter_sel :
                     hit_atten     ? atten :
                     hit_int_lo    ? int_lo :
                     hit_int_hi    ? int_hi :
                     hit_frac_lo   ? frac_lo :
                     hit_frac_mid  ? frac_mid :
                     hit_frac_hi   ? frac_hi :
                     hit_mod_lo    ? mod_lo :
                     hit_mod_hi    ? mod_hi :
                     hit_div_mode  ? div_mode :
                     hit_ref_div   ? ref_div : 8'h00;

  ////////////////////////////////////////////////////////////////////////
  // shared enable; read-only bits are held at zero by the mask
  always_ff @(posedge i_mclk)
  begin
    if (!i_reset_n)
      bb_enable <= RST_BB_ENABLE;
    else if (wr_bb_enable)
      bb_enable <= cfg.wdata & MASK_BB_ENABLE;
  end

  // amplifier gain selects; reserved pairs are stored as written
  always_ff @(posedge i_mclk)
  begin
    if (!i_reset_n)
    begin
      gain1 <= RST_GAIN;
      gain2 <= RST_GAIN;
      gain3 <= RST_GAIN;
    end
    else
    begin
      if (wr_gain1)
        gain1 <= cfg.wdata;
      if (wr_gain2)
        gain2 <= cfg.wdata;
      if (wr_gain3)
        gain3 <= cfg.wdata;
    end
  end

  // filter bandwidth; upper nibble never stores
  always_ff @(posedge i_mclk)
  begin
    if (!i_reset_n)
      filter_sel <= RST_FILTER;
    else if (wr_filter)
      filter_sel <= cfg.wdata & MASK_FILTER;
  end

  // step attenuator
  always_ff @(posedge i_mclk)
  begin
    if (!i_reset_n)
      atten <= RST_ATTEN;
    else if (wr_atten)
      atten <= cfg.wdata;
  end

  ////////////////////////////////////////////////////////////////////////
  // shadow bytes of the divider words; reads return the shadow, not
  // the active value, so software sees what it last wrote
  always_ff @(posedge i_mclk)
  begin
    if (!i_reset_n)
    begin
      int_lo   <= RST_INT_LO;
      int_hi   <= RST_INT_HI;
      frac_lo  <= RST_ZERO;
      frac_mid <= RST_ZERO;
      frac_hi  <= RST_ZERO;
    end
    else
    begin
      if (wr_int_lo)
        int_lo <= cfg.wdata;
      if (wr_int_hi)
        int_hi <= cfg.wdata;
      if (wr_frac_lo)
        frac_lo <= cfg.wdata;
      if (wr_frac_mid)
        frac_mid <= cfg.wdata;
      if (wr_frac_hi)
        frac_hi <= cfg.wdata;
    end
  end

  // auxiliary modulus is single buffered; top two bits read zero
  always_ff @(posedge i_mclk)
  begin
    if (!i_reset_n)
    begin
      mod_lo <= RST_ZERO;
      mod_hi <= RST_ZERO;
    end
    else
    begin
      if (wr_mod_lo)
        mod_lo <= cfg.wdata;
      if (wr_mod_hi)
        mod_hi <= cfg.wdata & MASK_MOD_HI;
    end
  end

  // divider mode and reference divider
  always_ff @(posedge i_mclk)
  begin
    if (!i_reset_n)
    begin
      div_mode <= RST_DIV_MODE;
      ref_div  <= RST_REF_DIV;
    end
    else
    begin
      if (wr_div_mode)
        div_mode <= cfg.wdata & MASK_DIV_MODE;
      if (wr_ref_div)
        ref_div <= cfg.wdata & MASK_REF_DIV;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // active divider words: both load together on the integer low byte write,
  // low byte from the write data, the rest from the shadows, so the synthesizer never sees a half update
  always_ff @(posedge i_mclk)
  begin
    if (!i_reset_n)
    begin
      o_integer_word          <= {RST_INT_HI, RST_INT_LO};
      o_primary_fraction_word <= {RST_ZERO, RST_ZERO, RST_ZERO};
    end
    else if (wr_int_lo)
    begin
      o_integer_word          <= {int_hi, cfg.wdata};
      o_primary_fraction_word <= {frac_hi, frac_mid, frac_lo};
    end
  end

  // one-cycle calibration request, in the same cycle as the commit
  always_ff @(posedge i_mclk)
  begin
    if (!i_reset_n)
      o_cal_start <= 1'b0;
    else
      o_cal_start <= wr_int_lo;
  end

  ////////////////////////////////////////////////////////////////////////
  // field outputs, registered so they change only after the bank does;
  // costs one cycle of latency against the register contents
  always_ff @(posedge i_mclk)
  begin
    if (!i_reset_n)
    begin
      o_shared_bias_enable      <= RST_BB_ENABLE[SHARED_BIAS_BIT];
      o_stage1_gain_q           <= RST_GAIN[GAIN_Q_LSB +: 2];
      o_stage1_gain_i           <= RST_GAIN[GAIN_I_LSB +: 2];
      o_stage2_gain_q           <= RST_GAIN[GAIN_Q_LSB +: 2];
      o_stage2_gain_i           <= RST_GAIN[GAIN_I_LSB +: 2];
      o_stage3_gain_q           <= RST_GAIN[GAIN_Q_LSB +: 2];
      o_stage3_gain_i           <= RST_GAIN[GAIN_I_LSB +: 2];
      o_filter_corner_q         <= RST_FILTER[FILT_Q_LSB +: 2];
      o_filter_corner_i         <= RST_FILTER[FILT_I_LSB +: 2];
      o_attenuation_q           <= RST_ATTEN[ATT_Q_LSB +: 4];
      o_attenuation_i           <= RST_ATTEN[ATT_I_LSB +: 4];
      o_aux_modulus             <= {RST_ZERO[5:0], RST_ZERO};
      o_prescaler_enable        <= RST_DIV_MODE[PRESCALE_BIT];
      o_feedback_divider_enable <= RST_DIV_MODE[FBDIV_BIT];
      o_reference_divide        <= RST_REF_DIV[4:0];
    end
    else
    begin
      o_shared_bias_enable      <= bb_enable[SHARED_BIAS_BIT];
      o_stage1_gain_q           <= gain1[GAIN_Q_LSB +: 2];
      o_stage1_gain_i           <= gain1[GAIN_I_LSB +: 2];
      o_stage2_gain_q           <= gain2[GAIN_Q_LSB +: 2];
      o_stage2_gain_i           <= gain2[GAIN_I_LSB +: 2];
      o_stage3_gain_q           <= gain3[GAIN_Q_LSB +: 2];
      o_stage3_gain_i           <= gain3[GAIN_I_LSB +: 2];
      o_filter_corner_q         <= filter_sel[FILT_Q_LSB +: 2];
      o_filter_corner_i         <= filter_sel[FILT_I_LSB +: 2];
      o_attenuation_q           <= atten[ATT_Q_LSB +: 4];
      o_attenuation_i           <= atten[ATT_I_LSB +: 4];
      o_aux_modulus             <= {mod_hi[5:0], mod_lo};
      o_prescaler_enable        <= div_mode[PRESCALE_BIT];
      o_feedback_divider_enable <= div_mode[FBDIV_BIT];
      o_reference_divide        <= ref_div[4:0];
    end
  end
endmodule

// ===== bbsd_pkg.sv
package bbsd_pkg;
  localparam int ADDR_W = 15;
  localparam int DATA_W = 8;
  localparam logic [4:0] LAST_ADDR_BIT = 5'h0f;
  localparam logic [4:0] LAST_FRAME_BIT = 5'h17;
  localparam logic [4:0] FIRST_DATA_BIT = 5'h10;

  ////////////////////////////////////////////////////////////////////////
  // register offsets
  localparam logic [14:0] OFF_BB_ENABLE = 15'h0132;
  localparam logic [14:0] OFF_GAIN1 = 15'h0133;
  localparam logic [14:0] OFF_GAIN2 = 15'h0134;
  localparam logic [14:0] OFF_GAIN3 = 15'h0135;
  localparam logic [14:0] OFF_FILTER = 15'h013c;
  localparam logic [14:0] OFF_ATTEN = 15'h0140;
  localparam logic [14:0] OFF_INT_LO = 15'h0200;
  localparam logic [14:0] OFF_INT_HI = 15'h0201;
  localparam logic [14:0] OFF_FRAC_LO = 15'h0202;
  localparam logic [14:0] OFF_FRAC_MID = 15'h0203;
  localparam logic [14:0] OFF_FRAC_HI = 15'h0204;
  localparam logic [14:0] OFF_MOD_LO = 15'h0208;
  localparam logic [14:0] OFF_MOD_HI = 15'h0209;
  localparam logic [14:0] OFF_DIV_MODE = 15'h020b;
  localparam logic [14:0] OFF_REF_DIV = 15'h020c;

  ////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [7:0] RST_BB_ENABLE = 8'h01;
  localparam logic [7:0] RST_GAIN = 8'hee;
  localparam logic [7:0] RST_FILTER = 8'h0a;
  localparam logic [7:0] RST_ATTEN = 8'h77;
  localparam logic [7:0] RST_INT_LO = 8'h89;
  localparam logic [7:0] RST_INT_HI = 8'h01;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_DIV_MODE = 8'h01;
  localparam logic [7:0] RST_REF_DIV = 8'h03;

  ////////////////////////////////////////////////////////////////////////
  // writable bit masks; bits outside a mask are read-only zero
  localparam logic [7:0] MASK_BB_ENABLE = 8'h01;
  localparam logic [7:0] MASK_FILTER = 8'h0f;
  localparam logic [7:0] MASK_MOD_HI = 8'h3f;
  localparam logic [7:0] MASK_DIV_MODE = 8'h03;
  localparam logic [7:0] MASK_REF_DIV = 8'h1f;

  ////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int GAIN_Q_LSB = 4;
  localparam int GAIN_I_LSB = 0;
  localparam int FILT_Q_LSB = 2;
  localparam int FILT_I_LSB = 0;
  localparam int ATT_Q_LSB = 4;
  localparam int ATT_I_LSB = 0;
  localparam int SHARED_BIAS_BIT = 0;
  localparam int PRESCALE_BIT = 1;
  localparam int FBDIV_BIT = 0;
endpackage

// ===== bbsd_cfg_if.sv
`timescale 1ns/1ns
// one register access decoded from a serial frame
interface bbsd_cfg_if;
  logic [14:0] addr;
  logic [7:0]  wdata;
  logic        wr_stb;
  logic [7:0]  rdata;

  modport engine (output addr, output wdata, output wr_stb, input rdata);
  modport bank (input addr, input wdata, input wr_stb, output rdata);
endinterface

// ===== bbsd_spi_engine.sv
`timescale 1ns/1ns
// serial frame engine: r/w flag, 15 address bits, 8 data bits, msb first
module bbsd_spi_engine
  import bbsd_pkg::*;
(
  input  wire logic   i_mclk,
  input  wire logic   i_reset_n,
  input  wire logic   i_cs_n,
  input  wire logic   i_sclk,
  input  wire logic   i_sdi,
  output logic        o_sdo,
  output logic        o_sdo_oe_n,
  bbsd_cfg_if.engine  cfg
);
  logic        sclk_q;
  logic [4:0]  bit_cnt;
  logic [21:0] shift_in;
  logic        is_read;
  logic        load_pend;
  logic [7:0]  out_shift;

  // edges of the sampled serial clock, qualified by an open frame
  wire rise = i_sclk & ~sclk_q & ~i_cs_n;
  wire fall = ~i_sclk & sclk_q & ~i_cs_n;
  wire addr_done = rise && (bit_cnt == LAST_ADDR_BIT);
  wire frame_done = rise && (bit_cnt == LAST_FRAME_BIT);
  wire drive_bit = fall && is_read && (bit_cnt >= FIRST_DATA_BIT);

  always_ff @(posedge i_mclk)
    sclk_q <= i_reset_n ? i_sclk : 1'b0;

  ////////////////////////////////////////////////////////////////////////
  // bit counter and input shifter; a raised select abandons the frame
  always_ff @(posedge i_mclk)
  begin
    if (!i_reset_n || i_cs_n)
    begin
      bit_cnt  <= 5'h00;
      shift_in <= 22'h000000;
    end
    else if (rise)
    begin
      bit_cnt  <= frame_done ? 5'h00 : bit_cnt + 5'h01;
      shift_in <= {shift_in[20:0], i_sdi};
    end
  end

  // address and data capture; write strobe lasts one cycle
  always_ff @(posedge i_mclk)
  begin
    if (!i_reset_n)
    begin
      cfg.addr   <= 15'h0000;
      cfg.wdata  <= 8'h00;
      cfg.wr_stb <= 1'b0;
      is_read    <= 1'b0;
      load_pend  <= 1'b0;
    end
    else
    begin
      cfg.wr_stb <= frame_done & ~is_read;
      load_pend  <= addr_done;
      if (addr_done)
      begin
        cfg.addr <= {shift_in[13:0], i_sdi};
        is_read  <= shift_in[14];
      end
      if (frame_done)
        cfg.wdata <= {shift_in[6:0], i_sdi};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read data goes out on falling edges so the host samples it on rising
  always_ff @(posedge i_mclk)
  begin
    if (!i_reset_n || i_cs_n)
    begin
      out_shift  <= 8'h00;
      o_sdo      <= 1'b0;
      o_sdo_oe_n <= 1'b1;
    end
    else if (load_pend && is_read)
    begin
      out_shift  <= cfg.rdata;
      o_sdo_oe_n <= 1'b0;
    end
    else if (drive_bit)
    begin
      o_sdo     <= out_shift[7];
      out_shift <= {out_shift[6:0], 1'b0};
    end
  end
endmodule

// ===== bbsd_host_model.sv
`timescale 1ns/1ns
// serial host: 24-bit frames msb first, three mclk per sclk phase
module bbsd_host_model (
  input  wire logic i_mclk,
  input  wire logic i_sdo,
  output logic      o_cs_n,
  output logic      o_sclk,
  output logic      o_sdi
);
  // idle: deselected, clock parked low
  initial
  begin
    o_cs_n = 1'b1;
    o_sclk = 1'b0;
    o_sdi  = 1'b0;
  end

  // move just after an edge so the design never races the host
  task automatic tick(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask

  // one frame; read data is taken just before rises 17..24
  task automatic xfer(input logic rd, input logic [14:0] addr, input logic [7:0] wd, output logic [7:0] q);
    logic [23:0] sh;
    sh = {rd, addr, wd};
    q  = 8'h00;
    tick(1);
    o_cs_n = 1'b0;
    for (int b = 23; b >= 0; b--)
    begin
      o_sdi = sh[b];
      tick(3);
      if (b < 8)
        q[b] = i_sdo;
      o_sclk = 1'b1;
      tick(3);
      o_sclk = 1'b0;
    end
    tick(3);
    o_cs_n = 1'b1;
    o_sdi  = ~o_sdi; // a released line must not show the last bit
    tick(2);
  endtask
endmodule

// ===== bbsd_regs_assertions.sv
`timescale 1ns/1ns
module bbsd_regs_assertions (
  input wire logic        i_mclk,
  input wire logic        i_reset_n,
  input wire logic        i_cs_n,
  input wire logic        i_sclk,
  input wire logic        o_sdo_oe_n,
  input wire logic        o_shared_bias_enable,
  input wire logic [1:0]  o_filter_corner_q,
  input wire logic [3:0]  o_attenuation_q,
  input wire logic [15:0] o_integer_word,
  input wire logic [23:0] o_primary_fraction_word,
  input wire logic [13:0] o_aux_modulus,
  input wire logic        o_prescaler_enable,
  input wire logic        o_feedback_divider_enable,
  input wire logic [4:0]  o_reference_divide,
  input wire logic        o_cal_start
);
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_reset_n);

  ////////////////////////////////////////
  // release edge still shows what reset loaded
  sequence s_release;
    $rose(i_reset_n);
  endsequence
  sequence s_pulse;
    o_cal_start ##1 !o_cal_start;
  endsequence

  a_reset_bank: assert property (s_release |-> o_shared_bias_enable && o_integer_word == 16'h0189
    && o_feedback_divider_enable && !o_prescaler_enable) else $error("bank reset values wrong");
  a_reset_misc: assert property (s_release |-> o_reference_divide == 5'h03 && o_attenuation_q == 4'h7
    && o_filter_corner_q == 2'h2 && o_aux_modulus == 14'h0 && o_primary_fraction_word == 24'h0)
    else $error("field reset values wrong");
  a_cal_single: assert property ($rose(o_cal_start) |-> s_pulse) else $error("cal pulse too long");
  a_cal_cause: assert property (o_cal_start |-> $past(!i_cs_n && i_sclk, 2)) else $error("cal without frame");
  // divider words move only with the commit pulse, never byte by byte
  a_int_commit: assert property (!$stable(o_integer_word) |-> o_cal_start) else $error("int moved alone");
  a_frac_commit: assert property (!$stable(o_primary_fraction_word) |-> o_cal_start)
    else $error("fraction moved alone");
  a_mode_cause: assert property (!$stable({o_prescaler_enable, o_feedback_divider_enable}) |-> $past(!i_cs_n, 3))
    else $error("mode moved without frame");
  a_refdiv_cause: assert property (!$stable(o_reference_divide) |-> $past(!i_cs_n, 3))
    else $error("ref divide moved without frame");
  a_oe_release: assert property (i_cs_n ##1 i_cs_n |=> o_sdo_oe_n) else $error("sdo driven while deselected");
endmodule

bind bbsd_regs bbsd_regs_assertions u_chk (.i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_cs_n(i_cs_n),
  .i_sclk(i_sclk), .o_sdo_oe_n(o_sdo_oe_n), .o_shared_bias_enable(o_shared_bias_enable),
  .o_filter_corner_q(o_filter_corner_q), .o_attenuation_q(o_attenuation_q), .o_integer_word(o_integer_word),
  .o_primary_fraction_word(o_primary_fraction_word), .o_aux_modulus(o_aux_modulus),
  .o_prescaler_enable(o_prescaler_enable), .o_feedback_divider_enable(o_feedback_divider_enable),
  .o_reference_divide(o_reference_divide), .o_cal_start(o_cal_start));

// ===== tb_top.sv
`timescale 1ns/1ns
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin errors++; $display("wrong value %s exp %0h got %0h", nm, e, g); end end
module tb_top;
  import bbsd_pkg::*;
  logic        i_mclk, i_reset_n, i_cs_n, i_sclk, i_sdi, o_sdo, o_sdo_oe_n, o_shared_bias_enable;
  logic [1:0]  o_stage1_gain_q, o_stage1_gain_i, o_stage2_gain_q, o_stage2_gain_i, o_stage3_gain_q, o_stage3_gain_i;
  logic [1:0]  o_filter_corner_q, o_filter_corner_i;
  logic [3:0]  o_attenuation_q, o_attenuation_i;
  logic [15:0] o_integer_word;
  logic [23:0] o_primary_fraction_word;
  logic [13:0] o_aux_modulus;
  logic        o_prescaler_enable, o_feedback_divider_enable, o_cal_start;
  logic [4:0]  o_reference_divide;
  logic [7:0]  rd_q;
  int          errors, num_checks, cal_cnt, cnt;
  logic [14:0] addr_tab [15] = '{15'h132, 15'h133, 15'h134, 15'h135, 15'h13c, 15'h140, 15'h200, 15'h201,
                                 15'h202, 15'h203, 15'h204, 15'h208, 15'h209, 15'h20b, 15'h20c};
  logic [7:0]  rst_tab [15] = '{8'h01, 8'hee, 8'hee, 8'hee, 8'h0a, 8'h77, 8'h89, 8'h01, 8'h00, 8'h00, 8'h00,
                                8'h00, 8'h00, 8'h01, 8'h03};
  logic [7:0]  mask_tab [15] = '{8'h01, 8'hff, 8'hff, 8'hff, 8'h0f, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff,
                                 8'hff, 8'h3f, 8'h03, 8'h1f};

  bbsd_regs DUT (.*);
  bbsd_host_model host (.i_mclk(i_mclk), .i_sdo(o_sdo), .o_cs_n(i_cs_n), .o_sclk(i_sclk), .o_sdi(i_sdi));

  ////////////////////////////////////////
  // clock and commit pulse counter
  initial
    i_mclk = 1'b0;
  always #5 i_mclk = ~i_mclk;
  always @(posedge i_mclk)
    if (o_cal_start === 1'b1)
      cal_cnt <= cal_cnt + 1;

  task automatic wr(input logic [14:0] a, input logic [7:0] d);
    logic [7:0] unused;
    host.xfer(1'b0, a, d, unused);
  endtask
  task automatic rd(input logic [14:0] a, input logic [7:0] e);
    host.xfer(1'b1, a, 8'h00, rd_q);
    `CHK($sformatf("reg %0h", a), e, rd_q)
  endtask
  task automatic close_out;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // a hung frame must not stall the run; the 66 frames fit easily
  initial
  begin
    repeat (60000) @(posedge i_mclk);
    errors++;
    close_out();
  end

  ////////////////////////////////////////
  // main sequence
  initial
  begin
    i_reset_n = 1'b0;
    repeat (20) @(posedge i_mclk);
    #1;
    i_reset_n = 1'b1;
    `CHK("bias gains", {o_shared_bias_enable, o_stage1_gain_q, o_stage1_gain_i, o_stage2_gain_q, o_stage2_gain_i, o_stage3_gain_q, o_stage3_gain_i}, 13'h1aaa)
    `CHK("filter atten", {o_filter_corner_q, o_filter_corner_i, o_attenuation_q, o_attenuation_i}, 12'ha77)
    `CHK("dividers", {o_integer_word, o_primary_fraction_word, o_aux_modulus}, {16'h0189, 24'h0, 14'h0})
    `CHK("mode refdiv", {o_prescaler_enable, o_feedback_divider_enable, o_reference_divide}, 7'h23)
    `CHK("cal idle", o_cal_start, 1'b0)
    for (int i = 0; i < 15; i++)
      rd(addr_tab[i], rst_tab[i]);
    // staged bytes stay invisible until the low integer byte lands
    wr(15'h201, 8'h12);
    wr(15'h202, 8'h34);
    wr(15'h203, 8'h56);
    wr(15'h204, 8'h78);
    `CHK("int held", o_integer_word, 16'h0189)
    `CHK("frac held", o_primary_fraction_word, 24'h0)
    rd(15'h201, 8'h12);
    cnt = cal_cnt;
    wr(15'h200, 8'h9a);
    `CHK("cal pulses", cal_cnt, cnt + 1)
    `CHK("int word", o_integer_word, 16'h129a)
    `CHK("frac word", o_primary_fraction_word, 24'h785634)
    // reserved gain pairs rewritten with their reset value
    wr(15'h133, 8'hde);
    wr(15'h134, 8'hef);
    wr(15'h135, 8'hcd);
    `CHK("gains", {o_stage1_gain_q, o_stage1_gain_i, o_stage2_gain_q, o_stage2_gain_i, o_stage3_gain_q, o_stage3_gain_i}, 12'h6b1)
    rd(15'h134, 8'hef);
    for (int c = 0; c < 4; c++)
    begin
      wr(15'h13c, 8'(c * 4 + 3 - c));
      `CHK("filter", {o_filter_corner_q, o_filter_corner_i}, 4'(c * 4 + 3 - c))
    end
    wr(15'h140, 8'h5c);
    `CHK("atten", {o_attenuation_q, o_attenuation_i}, 8'h5c)
    wr(15'h208, 8'h03);
    wr(15'h209, 8'hc0);
    `CHK("modulus", o_aux_modulus, 14'h0003)
    wr(15'h20b, 8'hfe);
    `CHK("mode", {o_prescaler_enable, o_feedback_divider_enable}, 2'b10)
    wr(15'h20c, 8'hf5);
    `CHK("refdiv", o_reference_divide, 5'h15)
    rd(15'h205, 8'h00);
    // all-ones writes expose every read-only zero bit
    for (int i = 0; i < 15; i++)
    begin
      wr(addr_tab[i], 8'hff);
      rd(addr_tab[i], mask_tab[i]);
    end
    wr(15'h132, 8'h00);
    `CHK("bias off", o_shared_bias_enable, 1'b0)
    // second reset in mid-run
    i_reset_n = 1'b0;
    repeat (20) @(posedge i_mclk);
    #1;
    i_reset_n = 1'b1;
    `CHK("int after reset", o_integer_word, 16'h0189)
    `CHK("bias after reset", o_shared_bias_enable, 1'b1)
    close_out();
  end
endmodule
